// >>> hdl/tcc_ctrl2.sv
// Second timer control register: preload of channel controls, trigger
// output select, input-one xor, idle levels, DMA timing.
// Assumes timer core events arrive on mclk; channel pins are asynchronous.
// Operation
// - Preload off: channel controls apply at once
// - Update source adds trigger input rising edge
// - DMA on channel event or update
// - Trigger output: reset, enable, update
// - Trigger output pulses on channel event flag
// - Trigger output from compare references one-four
// - Input one: pin one or xor
// - Channel one idle level when outputs off
// - Complementary idle level when outputs off
// - Idle bits locked when lock level nonzero
// - Channel two idle like channel one
//
// The AXI4-Lite register port was decided locally.
module tcc_ctrl2 (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tcc_pkg::ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic commutation_generate,
    input wire logic trigger_input,
    input wire logic timer_reset,
    input wire logic counter_enable,
    input wire logic update_event,
    input wire logic [3:0] channel_event,
    input wire logic [3:0] compare_reference,
    input wire logic main_output_enable,
    input wire logic [1:0] lock_level,
    input wire logic [2:0] channel_pin,
    output logic [3:0] channel_dma_req,
    output logic trigger_output,
    output logic timer_input_one,
    output logic [15:0] channel_ctrl_active,
    output logic ch1_idle_out,
    output logic ch1_comp_idle_out,
    output logic ch2_idle_out,
    output logic idle_active
);
    import tcc_pkg::*;

    logic [15:0] ctrl2_r;
    logic [15:0] chshd_r;
    logic [15:0] chact_r;
    logic trig_d_r;
    logic [2:0] pin_s;
    tcc_wstate_type wst_r;
    logic [ADDR_W-1:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_have_r;
    logic w_have_r;
    logic wr_fire;
    logic [15:0] wmerge;
    logic trig_rise;
    logic comm_load;
    logic channel_preload_control;
    logic control_update_source;
    logic channel_dma_timing;
    logic [2:0] master_trigger_select;
    logic input_one_xor_select;
    assign channel_preload_control = ctrl2_r[B_PRELOAD];
    assign control_update_source = ctrl2_r[B_UPDSRC];
    assign channel_dma_timing = ctrl2_r[B_DMATIM];
    assign master_trigger_select = ctrl2_r[B_MTS_LO +: 3];
    assign input_one_xor_select = ctrl2_r[B_XORSEL];
    tcc_sync #(.W(3)) u_pin_sync (
        .mclk(mclk),
        .rst_b(rst_b),
        .din(channel_pin),
        .dout(pin_s)
    );
    // Write channel: address and data taken in either order
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            aw_have_r <= 1'b0;
            awaddr_r <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_have_r <= 1'b1;
            awaddr_r <= s_axi_awaddr;
        end else if (wr_fire) begin
            aw_have_r <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            w_have_r <= 1'b0;
            wdata_r <= '0;
            wstrb_r <= '0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_have_r <= 1'b1;
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_have_r <= 1'b0;
        end
    end
    assign wr_fire = (wst_r == WS_IDLE) && aw_have_r && w_have_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wst_r <= WS_IDLE;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end else begin
            case (wst_r)
                WS_IDLE: begin
                    if (wr_fire) begin
                        wst_r <= WS_RESP;
                        s_axi_bvalid <= 1'b1;
                        if (awaddr_r == OFF_CTRL2 || awaddr_r == OFF_CHCTL
                            || awaddr_r == OFF_CHSHD || awaddr_r == OFF_STAT) begin
                            s_axi_bresp <= RESP_OKAY;
                        end else begin
                            s_axi_bresp <= RESP_SLVERR;
                        end
                    end
                end
                WS_RESP: begin
                    if (s_axi_bready) begin
                        s_axi_bvalid <= 1'b0;
                        wst_r <= WS_HOLD;
                    end
                end
                default: begin
                    wst_r <= WS_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_have_r && !(s_axi_awvalid && s_axi_awready)
                && (wst_r == WS_IDLE);
            s_axi_wready <= !w_have_r && !(s_axi_wvalid && s_axi_wready)
                && (wst_r == WS_IDLE);
        end
    end

    // Byte-lane merge of the old low halfword with the write data
    always_comb begin
        wmerge = ctrl2_r;
        if (awaddr_r == OFF_CHCTL) begin
            wmerge = chshd_r;
        end
        if (wstrb_r[0]) begin
            wmerge[7:0] = wdata_r[7:0];
        end
        if (wstrb_r[1]) begin
            wmerge[15:8] = wdata_r[15:8];
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl2_r <= CTRL2_RST;
        end else if (wr_fire && awaddr_r == OFF_CTRL2) begin
            if (lock_level != LOCK_OFF) begin
                ctrl2_r <= ((wmerge & CTRL2_WMASK) & ~IDLE_MASK) | (ctrl2_r & IDLE_MASK);
            end else begin
                ctrl2_r <= wmerge & CTRL2_WMASK;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            chshd_r <= CHCTL_RST;
        end else if (wr_fire && awaddr_r == OFF_CHCTL) begin
            chshd_r <= wmerge;
        end
    end
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trig_d_r <= 1'b0;
        end else begin
            trig_d_r <= trigger_input;
        end
    end
    assign trig_rise = trigger_input && !trig_d_r;
    assign comm_load = commutation_generate || (control_update_source && trig_rise);
    // Active channel controls; complementary channels may be preloaded
    for (genvar c = 0; c < NCH; c++) begin : g_ch
        always_ff @(posedge mclk or negedge rst_b) begin
            if (!rst_b) begin
                chact_r[c*CHF_W +: CHF_W] <= CHCTL_RST[c*CHF_W +: CHF_W];
            end else if (!COMP_CH[c] || !channel_preload_control) begin
                chact_r[c*CHF_W +: CHF_W] <= chshd_r[c*CHF_W +: CHF_W];
            end else if (comm_load) begin
                chact_r[c*CHF_W +: CHF_W] <= chshd_r[c*CHF_W +: CHF_W];
            end
        end
    end
    assign channel_ctrl_active = chact_r;
    // Read channel: one cycle to rvalid
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= RESP_OKAY;
            if (s_axi_araddr == OFF_CTRL2) begin
                s_axi_rdata <= {16'h0000, ctrl2_r};
            end else if (s_axi_araddr == OFF_CHCTL) begin
                s_axi_rdata <= {16'h0000, chshd_r};
            end else if (s_axi_araddr == OFF_CHSHD) begin
                s_axi_rdata <= {16'h0000, chact_r};
            end else if (s_axi_araddr == OFF_STAT) begin
                s_axi_rdata <= {24'h000000, trigger_output, timer_input_one,
                    lock_level, channel_dma_req};
            end else begin
                s_axi_rdata <= '0;
                s_axi_rresp <= RESP_SLVERR;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            channel_dma_req <= '0;
        end else if (channel_dma_timing) begin
            channel_dma_req <= {NCH{update_event}};
        end else begin
            channel_dma_req <= channel_event;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            trigger_output <= 1'b0;
        end else begin
            case (master_trigger_select)
                MTS_RESET: trigger_output <= timer_reset;
                MTS_ENABLE: trigger_output <= counter_enable;
                MTS_UPDATE: trigger_output <= update_event;
                MTS_PULSE: trigger_output <= |channel_event;
                MTS_OC1: trigger_output <= compare_reference[0];
                MTS_OC2: trigger_output <= compare_reference[1];
                MTS_OC3: trigger_output <= compare_reference[2];
                default: trigger_output <= compare_reference[3];
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            timer_input_one <= 1'b0;
        end else if (input_one_xor_select) begin
            timer_input_one <= ^pin_s;
        end else begin
            timer_input_one <= pin_s[0];
        end
    end

    // Idle levels follow the control bits whatever main_output_enable is; idle_active flags main outputs off
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ch1_idle_out <= 1'b0;
            ch1_comp_idle_out <= 1'b0;
            ch2_idle_out <= 1'b0;
            idle_active <= 1'b0;
        end else begin
            idle_active <= !main_output_enable;
            ch1_idle_out <= ctrl2_r[B_CH1IDLE] && COMP_CH[0];
            ch1_comp_idle_out <= ctrl2_r[B_CH1NIDLE];
            ch2_idle_out <= ctrl2_r[B_CH2IDLE] && COMP_CH[1];
        end
    end

    AST_IDLE_LOCK: assert property (@(posedge mclk) disable iff (!rst_b)
        (lock_level != LOCK_OFF) |=> $stable(ctrl2_r[10:8]))
        else $error("idle bits changed under lock");
    AST_RSVD_ZERO: assert property (@(posedge mclk) disable iff (!rst_b)
        ctrl2_r[1] == 1'b0 && ctrl2_r[15:11] == 5'h00)
        else $error("reserved bits set");
    AST_IMMEDIATE: assert property (@(posedge mclk) disable iff (!rst_b)
        !channel_preload_control && $stable(chshd_r) |=> chact_r == $past(chshd_r))
        else $error("channel controls not applied");
    AST_CH4_FREE: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> chact_r[15:12] == $past(chshd_r[15:12]))
        else $error("channel four held by preload");
    AST_HOLD_PRE: assert property (@(posedge mclk) disable iff (!rst_b)
        channel_preload_control && !comm_load |=> $stable(chact_r[11:0]))
        else $error("preloaded controls changed");
    AST_DMA_UPD: assert property (@(posedge mclk) disable iff (!rst_b)
        channel_dma_timing && update_event |=> channel_dma_req == 4'hf)
        else $error("dma missing on update");
    AST_TRG_UPD: assert property (@(posedge mclk) disable iff (!rst_b)
        master_trigger_select == MTS_UPDATE && update_event |=> trigger_output)
        else $error("update not on trigger output");
    AST_TRG_PULSE: assert property (@(posedge mclk) disable iff (!rst_b)
        master_trigger_select == MTS_PULSE && channel_event == 4'h0 |=> !trigger_output)
        else $error("spurious trigger pulse");
    AST_TRG_OC1: assert property (@(posedge mclk) disable iff (!rst_b)
        master_trigger_select == MTS_OC1 |=> trigger_output == $past(compare_reference[0]))
        else $error("trigger not from reference one");
    AST_XOR: assert property (@(posedge mclk) disable iff (!rst_b)
        input_one_xor_select |=> timer_input_one == ^$past(pin_s))
        else $error("input one xor wrong");
    AST_IDLE1: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> ch1_idle_out == $past(ctrl2_r[8]))
        else $error("channel one idle level wrong");
    AST_IDLE1N: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> ch1_comp_idle_out == $past(ctrl2_r[9]))
        else $error("complementary idle level wrong");
    AST_IDLE2: assert property (@(posedge mclk) disable iff (!rst_b)
        1'b1 |=> ch2_idle_out == $past(ctrl2_r[10]))
        else $error("channel two idle level wrong");
endmodule // tcc_ctrl2

// >>> hdl/tcc_pkg.sv
// Constants for the second timer control register block.
// Assumes a 32-bit AXI4-Lite register slave clocked by mclk.
package tcc_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CTRL2 = 8'h04;
    localparam logic [7:0] OFF_CHCTL = 8'h20;
    localparam logic [7:0] OFF_CHSHD = 8'h24;
    localparam logic [7:0] OFF_STAT = 8'h28;
    // Control-two field positions
    localparam int B_PRELOAD = 0;
    localparam int B_UPDSRC = 2;
    localparam int B_DMATIM = 3;
    localparam int B_MTS_LO = 4;
    localparam int B_XORSEL = 7;
    localparam int B_CH1IDLE = 8;
    localparam int B_CH1NIDLE = 9;
    localparam int B_CH2IDLE = 10;
    // Writable bits; bit 1 and bits above 10 stay zero
    localparam logic [15:0] CTRL2_WMASK = 16'h07fd;
    localparam logic [15:0] IDLE_MASK = 16'h0700;
    localparam logic [15:0] CTRL2_RST = 16'h0000;
    // Channel control: per channel 4 bits {mode[1:0], comp_en, en}
    localparam int CHF_W = 4;
    localparam int NCH = 4;
    // Channels 1..3 have complementary outputs
    localparam logic [3:0] COMP_CH = 4'h7;
    localparam logic [15:0] CHCTL_RST = 16'h0000;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] MTS_RESET = 3'h0;
    localparam logic [2:0] MTS_ENABLE = 3'h1;
    localparam logic [2:0] MTS_UPDATE = 3'h2;
    localparam logic [2:0] MTS_PULSE = 3'h3;
    localparam logic [2:0] MTS_OC1 = 3'h4;
    localparam logic [2:0] MTS_OC2 = 3'h5;
    localparam logic [2:0] MTS_OC3 = 3'h6;
    localparam logic [2:0] MTS_OC4 = 3'h7;
    localparam logic [1:0] LOCK_OFF = 2'h0;
    typedef enum logic [2:0] {
        WS_IDLE = 3'b001,
        WS_RESP = 3'b010,
        WS_HOLD = 3'b100
    } tcc_wstate_type;
endpackage

// >>> hdl/tcc_sync.sv
// Two-flop synchroniser bank for pin inputs.
// Assumes inputs are asynchronous to mclk.
module tcc_sync #(
    parameter int W = 1
) (
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    logic [W-1:0] meta_r;
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            meta_r <= '0;
            dout <= '0;
        end else begin
            meta_r <= din;
            dout <= meta_r;
        end
    end
endmodule // tcc_sync

// >>> tb/tcc_pin_model.sv
// Far-side model: channel pins feeding the block and a slave timer
// that counts rises on the trigger output.
// Assumes pins are asynchronous, so they change away from mclk edges.
module tcc_pin_model (
    input wire logic mclk,
    input wire logic [2:0] pin_level,
    input wire logic trigger_output,
    output logic [2:0] channel_pin,
    output int trg_rise
);
    timeunit 1ns;
    timeprecision 100ps;
    logic trg_q;
    initial begin
        channel_pin = 3'h0;
        trg_rise = 0;
        trg_q = 1'b0;
    end
    // Lag keeps pin changes off the sampling edge, as a real pin would be
    always @(pin_level) begin
        channel_pin <= #1.3 pin_level;
    end
    // A slave timer sees one event per rise, so a stuck level counts once
    always @(posedge mclk) begin
        if (trigger_output && !trg_q) begin
            trg_rise <= trg_rise + 1;
        end
        trg_q <= trigger_output;
    end
endmodule // tcc_pin_model

// >>> tb/testbench.sv
// Self-checking bench for the second timer control register block.
// Assumes the AXI4-Lite slave timing and the one-cycle output delays of tcc_ctrl2.
`define CHK(got, exp) begin \
    checks_done++; \
    if ((got) !== (exp)) begin \
        n_mismatch++; \
        $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); \
    end \
end
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    import tcc_pkg::*;
    int n_mismatch = 0;
    int checks_done = 0;
    logic mclk = 1'b0, rst_b = 1'b0;
    logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = 4'h3;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic commutation_generate = 1'b0, trigger_input = 1'b0, timer_reset = 1'b0;
    logic counter_enable = 1'b0, update_event = 1'b0, main_output_enable = 1'b1;
    logic [3:0] channel_event = 4'h0, compare_reference = 4'h0;
    logic [1:0] lock_level = LOCK_OFF;
    logic [2:0] pin_level = 3'h0;
    logic [2:0] channel_pin;
    logic [3:0] channel_dma_req;
    logic trigger_output, timer_input_one, ch1_idle_out, ch1_comp_idle_out;
    logic ch2_idle_out, idle_active;
    logic [15:0] channel_ctrl_active;
    int trg_rise;

    tcc_ctrl2 tcc_ctrl2_i (.mclk, .rst_b, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .commutation_generate,
        .trigger_input, .timer_reset, .counter_enable, .update_event, .channel_event,
        .compare_reference, .main_output_enable, .lock_level, .channel_pin,
        .channel_dma_req, .trigger_output, .timer_input_one, .channel_ctrl_active,
        .ch1_idle_out, .ch1_comp_idle_out, .ch2_idle_out, .idle_active);
    tcc_pin_model tcc_pin_model_i (.mclk, .pin_level, .trigger_output, .channel_pin,
        .trg_rise);

    always #2.5 mclk = ~mclk;

    task automatic finish_test();
        $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // Address and data offered together; bready held until the answer
    task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, input logic [1:0] er);
        bit aw_ok = 0;
        bit w_ok = 0;
        bit b_ok = 0;
        int n = 0;
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        while (!b_ok && n < 100) begin
            @(posedge mclk);
            n++;
            if (s_axi_awready && !aw_ok) begin
                aw_ok = 1;
                s_axi_awvalid <= 1'b0;
            end
            if (s_axi_wready && !w_ok) begin
                w_ok = 1;
                s_axi_wvalid <= 1'b0;
            end
            if (s_axi_bvalid) begin
                b_ok = 1;
                s_axi_bready <= 1'b0;
                `CHK(s_axi_bresp, er)
            end
        end
        if (!b_ok) n_mismatch++;
    endtask

    task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] ed, input logic [1:0] er);
        bit ar_ok = 0;
        bit r_ok = 0;
        int n = 0;
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        while (!r_ok && n < 100) begin
            @(posedge mclk);
            n++;
            if (s_axi_arready && !ar_ok) begin
                ar_ok = 1;
                s_axi_arvalid <= 1'b0;
            end
            if (s_axi_rvalid) begin
                r_ok = 1;
                s_axi_rready <= 1'b0;
                `CHK(s_axi_rdata, ed)
                `CHK(s_axi_rresp, er)
            end
        end
        if (!r_ok) n_mismatch++;
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    task automatic t_regs();
        rd(OFF_CTRL2, 32'h0, RESP_OKAY);
        rd(OFF_CHSHD, 32'h0, RESP_OKAY);
        wr(OFF_CTRL2, 32'hffffffff, RESP_OKAY);
        rd(OFF_CTRL2, 32'h000007fd, RESP_OKAY);
        // Low lane only: the idle bits in the high lane must survive
        s_axi_wstrb <= 4'h1;
        wr(OFF_CTRL2, 32'h0, RESP_OKAY);
        s_axi_wstrb <= 4'h3;
        rd(OFF_CTRL2, 32'h00000700, RESP_OKAY);
        main_output_enable <= 1'b0;
        settle(2);
        `CHK({ch1_idle_out, ch1_comp_idle_out, ch2_idle_out, idle_active}, 4'hf)
        wr(OFF_CTRL2, 32'h0, RESP_OKAY);
        wr(8'h40, 32'h1, RESP_SLVERR);
        rd(8'h40, 32'h0, RESP_SLVERR);
        main_output_enable <= 1'b1;
        settle(2);
        `CHK({ch1_idle_out, ch1_comp_idle_out, ch2_idle_out, idle_active}, 4'h0)
    endtask

    task automatic t_lock();
        wr(OFF_CTRL2, 32'h0700, RESP_OKAY);
        for (int l = 1; l < 4; l++) begin
            lock_level <= 2'(l);
            wr(OFF_CTRL2, 32'h0080, RESP_OKAY);
            rd(OFF_CTRL2, 32'h0780, RESP_OKAY);
            rd(OFF_STAT, 32'(l) << 4, RESP_OKAY);
        end
        lock_level <= LOCK_OFF;
        wr(OFF_CTRL2, 32'h0, RESP_OKAY);
        rd(OFF_CTRL2, 32'h0, RESP_OKAY);
    endtask

    task automatic pulse(input bit comm);
        @(posedge mclk);
        if (comm) commutation_generate <= 1'b1;
        else trigger_input <= 1'b1;
        @(posedge mclk);
        commutation_generate <= 1'b0;
        trigger_input <= 1'b0;
        settle(3);
    endtask

    task automatic t_preload();
        wr(OFF_CTRL2, 32'h0, RESP_OKAY);
        wr(OFF_CHCTL, 32'habcd, RESP_OKAY);
        settle(2);
        `CHK(channel_ctrl_active, 16'habcd)
        wr(OFF_CTRL2, 32'h1, RESP_OKAY);
        wr(OFF_CHCTL, 32'h1234, RESP_OKAY);
        settle(2);
        `CHK(channel_ctrl_active, 16'h1bcd)
        pulse(1'b0);
        `CHK(channel_ctrl_active, 16'h1bcd)
        pulse(1'b1);
        `CHK(channel_ctrl_active, 16'h1234)
        wr(OFF_CTRL2, 32'h5, RESP_OKAY);
        wr(OFF_CHCTL, 32'h5678, RESP_OKAY);
        settle(2);
        `CHK(channel_ctrl_active, 16'h5234)
        pulse(1'b0);
        `CHK(channel_ctrl_active, 16'h5678)
        // The active copy is read-only: a write must be answered and dropped
        wr(OFF_CHSHD, 32'h0, RESP_OKAY);
        rd(OFF_CHSHD, 32'h5678, RESP_OKAY);
    endtask

    task automatic t_dma();
        for (int s = 0; s < 2; s++) begin
            wr(OFF_CTRL2, s ? 32'h8 : 32'h0, RESP_OKAY);
            @(posedge mclk);
            channel_event <= 4'h5;
            @(posedge mclk);
            channel_event <= 4'h0;
            update_event <= 1'b1;
            #1 `CHK(channel_dma_req, s ? 4'h0 : 4'h5)
            @(posedge mclk);
            update_event <= 1'b0;
            #1 `CHK(channel_dma_req, s ? 4'hf : 4'h0)
        end
    endtask

    task automatic src(input logic [7:0] v);
        timer_reset <= v[0];
        counter_enable <= v[1];
        update_event <= v[2];
        channel_event <= {1'b0, v[3], 2'b00};
        compare_reference <= v[7:4];
    endtask

    // Every other source is raised first, so a wrong selection shows up
    task automatic t_trigger();
        int base;
        base = trg_rise;
        for (int m = 0; m < 8; m++) begin
            wr(OFF_CTRL2, 32'(m) << 4, RESP_OKAY);
            @(posedge mclk);
            src(~(8'h1 << m));
            @(posedge mclk);
            src(8'h1 << m);
            #1 `CHK(trigger_output, 1'b0)
            @(posedge mclk);
            src(8'h0);
            #1 `CHK(trigger_output, 1'b1)
            settle(1);
            `CHK(trigger_output, 1'b0)
        end
        `CHK(trg_rise - base, 8)
    endtask

    task automatic t_input();
        for (int x = 0; x < 2; x++) begin
            wr(OFF_CTRL2, x ? 32'h80 : 32'h0, RESP_OKAY);
            for (int p = 0; p < 8; p++) begin
                @(posedge mclk);
                pin_level <= 3'(p);
                settle(5);
                `CHK(timer_input_one, x ? ^3'(p) : p[0])
            end
        end
    endtask

    // A reset in mid-run must clear every register, shadow and active copy
    task automatic t_reset();
        pin_level <= 3'h0;
        wr(OFF_CTRL2, 32'h07fd, RESP_OKAY);
        wr(OFF_CHCTL, 32'h9abc, RESP_OKAY);
        @(posedge mclk);
        rst_b <= 1'b0;
        settle(4);
        `CHK({channel_ctrl_active, ch1_idle_out, trigger_output}, 18'h0)
        @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        rd(OFF_CTRL2, 32'h0, RESP_OKAY);
        rd(OFF_CHCTL, 32'h0, RESP_OKAY);
        rd(OFF_CHSHD, 32'h0, RESP_OKAY);
    endtask

    initial begin
        repeat (16) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (2) @(posedge mclk);
        t_regs();
        t_lock();
        t_preload();
        t_dma();
        t_trigger();
        t_input();
        t_reset();
        finish_test();
    end

    // The run needs about 400 cycles; seventy-five times that means a hang
    initial begin
        repeat (30000) @(posedge mclk);
        n_mismatch++;
        finish_test();
    end
endmodule // testbench
